// ==== bench/disc_sector_read_sequencer_tb.sv ====
// Self-checking bench for the sector read sequencer.
`timescale 1ns/1ns
`default_nettype none
module disc_sector_read_sequencer_tb;
    import dsr_pkg::*;
    logic             clk = 1'b0, rst_b = 1'b0, alert_pulse = 1'b0, cmd_start_pulse = 1'b0;
    logic             stop_request = 1'b0, addr_xmit_level = 1'b0;
    logic [FLG_N-1:0] ext_flag_set = '0;
    logic [CHAR_BITS-1:0] chan_word = 18'h2A5C3;   // Output word offered by the channel.
    logic             link_clk, pin_one, pin_zero, pin_wclk, pin_error;
    logic             read_cmd_level, receive_enable_level, cmd_change_permit;
    logic             data_clock_first, data_clock_late, settle_done_pulse;
    logic             sector_over_pulse_a, sector_over_pulse_b;
    logic [0:ACC_W-1] file_data_accumulator;
    dsr_ctl_s         host_ctl = '0;
    dsr_state_e       fsm_state;
    dsr_status_s      status;
    dsr_chan_s        chan;
    dsr_drive_s       drive;
    int               miscompares = 0, num_checks = 0, cyc = 0, waited;

    // Design with a short settling count; the scenarios drive every side input except chan_word, which keeps its initial value.
    dsr_top #(.SETTLE_CYC(20)) uut (.clk, .rst_b, .link_clk, .pin_one, .pin_zero, .pin_wclk,
        .pin_error, .host_ctl, .alert_pulse, .cmd_start_pulse, .addr_xmit_level,
        .stop_request, .ext_flag_set, .chan_word, .read_cmd_level,
        .receive_enable_level, .cmd_change_permit, .fsm_state, .status, .chan, .drive,
        .file_data_accumulator, .data_clock_first, .data_clock_late, .settle_done_pulse,
        .sector_over_pulse_a, .sector_over_pulse_b);
    dsr_drive_model drv (.link_clk, .pin_one, .pin_zero, .pin_wclk, .pin_error);

    // System clock and a hang guard that ends the run.
    always #10 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            miscompares++;
            summarize();
        end
    end

    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Waits a bounded time for a strobe and notes how many cycles it took.
    task automatic wait_hi(ref logic s);
        waited = 0;
        do
        begin
            @(posedge clk);
            #1;
            waited++;
        end
        while (s !== 1'b1 && waited < 400);
        chk(20'(s), 20'h1);
    endtask : wait_hi

    // Issues one control load with the given command and clear bit.
    task automatic ctl(input logic [1:0] cmd, input logic b28);
        @(posedge clk) host_ctl.ctl_cmd_bits <= cmd;
        host_ctl.control_word_bit28 <= b28;
        host_ctl.ctl_load <= 1'b1;
        @(posedge clk) host_ctl.ctl_load <= 1'b0;
        @(posedge clk) #1;
    endtask : ctl

    // Every command code with a programmed clear, then read kept and an address-load clear.
    task automatic t_cmd();
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk) ext_flag_set <= 9'h1FF;
            @(posedge clk) ext_flag_set <= 9'h000;
            ctl(2'(i), 1'b1);
            chk(20'(read_cmd_level), 20'(i == 2));
            chk(20'(status.flags), 20'h0);
        end
        @(posedge clk) ext_flag_set <= 9'h1FF;
        @(posedge clk) ext_flag_set <= 9'h000;
        ctl(CMD_READ, 1'b0);
        chk(20'(status.flags), 20'h1FF);
        @(posedge clk) host_ctl.addr_load <= 1'b1;
        @(posedge clk) host_ctl.addr_load <= 1'b0;
        @(posedge clk) #1 chk(20'(status.flags), 20'h0);
    endtask : t_cmd

    // Alert then start: the command goes to the drive and settling begins.
    task automatic go();
        @(posedge clk) alert_pulse <= 1'b1;
        @(posedge clk) alert_pulse <= 1'b0;
        cmd_start_pulse <= 1'b1;
        @(posedge clk) cmd_start_pulse <= 1'b0;
        #1;
    endtask : go

    // Alert, start, settle into the sector and refuse a command change.
    task automatic t_seq();
        go();
        chk(20'({fsm_state, drive.read_pulse}), 20'({ST_CMDW, 1'b1}));
        wait_hi(settle_done_pulse);
        chk(20'(waited), 20'd20);
        chk(20'({fsm_state, status.in_sector_iob24, cmd_change_permit}), 20'({ST_INSEC, 2'h2}));
        ctl(CMD_NOP, 1'b0);
        chk(20'(read_cmd_level), 20'h1);
    endtask : t_seq

    // One character, a stop bit that wraps the accumulator, then a drive error.
    task automatic t_read();
        for (int i = 0; i < CHAR_BITS; i++)
        begin
            fork
                drv.send((i == 0) ? 4'h1 : 4'h2);
                begin
                    wait_hi(data_clock_first);
                    chk(20'(chan.take_char), 20'(i == CHAR_BITS - 1));
                end
            join
        end
        repeat (6) @(posedge clk);
        #1 chk(20'(file_data_accumulator[2:19]), 20'h1);
        chk(20'(receive_enable_level), 20'h1);
        @(posedge clk) stop_request <= 1'b1;
        addr_xmit_level <= 1'b1;
        fork
            drv.send(4'h2);
            wait_hi(data_clock_first);
        join
        repeat (6) @(posedge clk);
        #1 chk(20'(receive_enable_level), 20'h0);
        chk(20'(file_data_accumulator), 20'h80000);
        drv.send(4'h8);
        repeat (8) @(posedge clk);
        #1 chk(20'(status.flags[FLG_CLK]), 20'h1);
    endtask : t_read

    // Sector end with the read kept, then a bus reset in command wait.
    task automatic t_end();
        wait_hi(sector_over_pulse_a);
        chk(20'(fsm_state), 20'(ST_FIN));
        wait_hi(sector_over_pulse_b);
        chk(20'(waited), 20'd100);
        chk(20'({fsm_state, drive.read_pulse}), 20'({ST_CMDW, 1'b1}));
        chk(20'(status.sector_passed_iob25), 20'h1);
        @(posedge clk) host_ctl.io_bus_reset <= 1'b1;
        @(posedge clk) host_ctl.io_bus_reset <= 1'b0;
        @(posedge clk) #1 chk(20'({fsm_state, status.flags}), 20'({ST_IDLE, 9'h000}));
        repeat (30) @(posedge clk);
        #1 chk(20'(fsm_state), 20'(ST_IDLE));
    endtask : t_end

    // Write sector: the late clock of each character loads the channel word.
    task automatic t_wr();
        ctl(CMD_WRITE, 1'b0);
        go();
        chk(20'({fsm_state, drive}), 20'({ST_CMDW, 2'h1}));
        wait_hi(settle_done_pulse);
        for (int i = 0; i < CHAR_BITS; i++)
        begin
            fork
                drv.send(4'h4);
                begin
                    wait_hi(data_clock_late);
                    @(posedge clk) #1 chk(20'(chan[1:0]), 20'({2{i == CHAR_BITS - 1}}));
                end
            join
        end
        chk(20'(file_data_accumulator[2:19]), 20'(chan_word));
    endtask : t_wr

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    // Reset for twelve cycles, then the scenarios in order.
    initial
    begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(20'({fsm_state, cmd_change_permit}), 20'({ST_IDLE, 1'b1}));
        t_cmd();
        t_seq();
        t_read();
        t_end();
        t_wr();
        summarize();
    end
endmodule : disc_sector_read_sequencer_tb
`default_nettype wire

// ==== bench/dsr_drive_model.sv ====
// Behavioural disc drive that sends link pulses on a gated link clock.
`timescale 1ns/1ns
`default_nettype none
module dsr_drive_model (
    // Gated link clock, still between pulses.
    output logic link_clk,
    // Pulse lines toward the block, low when idle.
    output logic pin_one,
    output logic pin_zero,
    output logic pin_wclk,
    output logic pin_error
);
    // Runs six link periods and raises the chosen lines for exactly one of them.
    task automatic send(input logic [3:0] p);
        for (int i = 0; i < 6; i++)
        begin
            #16 link_clk = 1'b1;
            #1 {pin_error, pin_wclk, pin_zero, pin_one} = (i == 2) ? p : 4'h0;
            #15 link_clk = 1'b0;
        end
    endtask : send

    // The clock stands low and every line is quiet until a pulse is sent.
    initial
    begin
        link_clk = 1'b0;
        {pin_error, pin_wclk, pin_zero, pin_one} = 4'h0;
    end
endmodule : dsr_drive_model
`default_nettype wire

// ==== hw/dsr_link.sv ====
// Link-clock front end that turns drive pulses into toggle events.
`timescale 1ns/1ns
`default_nettype none
module dsr_link
    import dsr_pkg::*;
(
    // Link clock from the drive and the common reset.
    input  wire logic             link_clk,
    input  wire logic             rst_b,
    // Drive pulses, each high for one link clock.
    input  wire logic             pin_one,
    input  wire logic             pin_zero,
    input  wire logic             pin_wclk,
    input  wire logic             pin_error,
    // One toggle level per event kind.
    output logic      [EVT_N-1:0] evt_tgl
);

    // Toggle state of the link side.
    typedef struct packed {
        logic [EVT_N-1:0] tgl;
    } dsr_link_s;

    dsr_link_s r;     // Registered toggles.
    dsr_link_s n;     // Next toggles.

    // Each pulse flips its toggle, so no event is lost across the crossing.
    always_comb
    begin
        n = r;
        n.tgl = r.tgl ^ {pin_error, pin_wclk, pin_zero, pin_one};
    end

    // Toggles start at zero.
    always_ff @(posedge link_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end

    assign evt_tgl = r.tgl;

endmodule : dsr_link
`default_nettype wire

// ==== hw/dsr_pkg.sv ====
// Shared constants, state codes and carrier types of the sector read sequencer.
package dsr_pkg;

    // System clock rate in MHz.
    localparam int CLK_MHZ = 50;

    // Quiet time that marks the end of a sector, in microseconds.
    localparam int GAP_US = 5;
    // Spacing of the two sector-over pulses, in microseconds.
    localparam int FIN_US = 2;
    // Settling time spent in command wait, in microseconds.
    localparam int SETTLE_US = 200;

    // Cycle counts derived from the times above.
    localparam int GAP_CYC = GAP_US * CLK_MHZ;
    localparam int FIN_CYC = FIN_US * CLK_MHZ;
    localparam int SETTLE_CYC_DEF = SETTLE_US * CLK_MHZ;

    // Interval timer width and its terminal values.
    localparam int TMR_W = 9;
    localparam logic [TMR_W-1:0] GAP_LAST = TMR_W'(GAP_CYC - 1);
    localparam logic [TMR_W-1:0] FIN_LAST = TMR_W'(FIN_CYC - 1);

    // Accumulator, bit-shift counter and word counter layout.
    localparam int ACC_W = 20;
    localparam int CHAR_BITS = 18;
    localparam int DA_TOP = 2;
    localparam int DA_LAST = 19;
    localparam int BSC_W = 5;
    localparam logic [BSC_W-1:0] BSC_OVF = 5'h14;
    localparam logic [BSC_W-1:0] BSC_PRESET = 5'h02;
    localparam logic [BSC_W-1:0] BSC_ZERO = 5'h00;
    localparam int WC_W = 8;
    localparam int WC_TOP = 7;

    // Command codes; bit 0 is the first command bit, bit 1 the second.
    localparam logic [1:0] CMD_NOP = 2'h0;
    localparam logic [1:0] CMD_WRITE = 2'h1;
    localparam logic [1:0] CMD_READ = 2'h2;
    localparam logic [1:0] CMD_RDCMP = 2'h3;

    // Positions of the nine error-status flags.
    localparam int FLG_ADDR = 0;
    localparam int FLG_CMD = 1;
    localparam int FLG_CLK = 2;
    localparam int FLG_LATE = 3;
    localparam int FLG_FILE = 4;
    localparam int FLG_PAR = 5;
    localparam int FLG_CMP = 6;
    localparam int FLG_SECT = 7;
    localparam int FLG_WLK = 8;
    localparam int FLG_N = 9;

    // Positions of the link events and of the data clock chain.
    localparam int EVT_ONE = 0;
    localparam int EVT_ZERO = 1;
    localparam int EVT_WCLK = 2;
    localparam int EVT_ERR = 3;
    localparam int EVT_N = 4;
    localparam int CH_DCK1 = 0;
    localparam int CH_DCK2 = 2;
    localparam int CH_DCK21 = 3;
    localparam int CH_DCK3 = 4;
    localparam int CH_N = 5;

    // File-control states covered by this block.
    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_ALERT = 5'h02,
        ST_CMDW  = 5'h04,
        ST_INSEC = 5'h08,
        ST_FIN   = 5'h10
    } dsr_state_e;

    // Status word read by the processor.
    typedef struct packed {
        logic             in_sector_iob24;
        logic             sector_passed_iob25;
        logic [FLG_N-1:0] flags;
    } dsr_status_s;

    // Character handshake toward the data channel.
    typedef struct packed {
        logic take_char;
        logic give_char;
        logic outword_load;
    } dsr_chan_s;

    // Command pulses toward the drive.
    typedef struct packed {
        logic read_pulse;
        logic write_pulse;
    } dsr_drive_s;

    // Processor-side control pulses and levels.
    typedef struct packed {
        logic       io_bus_reset;
        logic       addr_load;
        logic       ctl_load;
        logic       control_word_bit28;
        logic [1:0] ctl_cmd_bits;
    } dsr_ctl_s;

endpackage : dsr_pkg

// ==== hw/dsr_sync.sv ====
// Two-flop synchroniser for a group of toggle levels.
`timescale 1ns/1ns
`default_nettype none
module dsr_sync #(
    parameter int W = 4
) (
    // Destination clock and reset.
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Levels from the other domain and their synchronised copy.
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    // Both stages of the synchroniser.
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } dsr_sync_s;

    dsr_sync_s r;     // Registered stages.
    dsr_sync_s n;     // Next stages.

    // The first stage feeds only the second one.
    always_comb
    begin
        n = r;
        n.s1 = d;
        n.s2 = r.s1;
    end

    // Both stages reset to zero.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end

    assign q = r.s2;

endmodule : dsr_sync
`default_nettype wire

// ==== hw/dsr_top.sv ====
// Sector sequencer with serial read datapath, character handshake and status flags.
`timescale 1ns/1ns
`default_nettype none
module dsr_top #(
    parameter int SETTLE_CYC = dsr_pkg::SETTLE_CYC_DEF
) (
    // System clock and reset.
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    // Link clock and drive pulses on it.
    input  wire logic                    link_clk,
    input  wire logic                    pin_one,
    input  wire logic                    pin_zero,
    input  wire logic                    pin_wclk,
    input  wire logic                    pin_error,
    // Processor control and neighbouring sequencer inputs.
    input  wire dsr_pkg::dsr_ctl_s       host_ctl,
    input  wire logic                    alert_pulse,
    input  wire logic                    cmd_start_pulse,
    input  wire logic                    addr_xmit_level,
    input  wire logic                    stop_request,
    input  wire logic [dsr_pkg::FLG_N-1:0] ext_flag_set,
    // Output word from the data channel.
    input  wire logic [dsr_pkg::CHAR_BITS-1:0] chan_word,
    // Command and state levels.
    output logic                         read_cmd_level,
    output logic                         receive_enable_level,
    output logic                         cmd_change_permit,
    output var dsr_pkg::dsr_state_e      fsm_state,
    // Status, channel and drive groups.
    output var dsr_pkg::dsr_status_s     status,
    output var dsr_pkg::dsr_chan_s       chan,
    output var dsr_pkg::dsr_drive_s      drive,
    // Accumulator, position 0 on the left.
    output logic [0:dsr_pkg::ACC_W-1]    file_data_accumulator,
    // Timing strobes.
    output logic                         data_clock_first,
    output logic                         data_clock_late,
    output logic                         settle_done_pulse,
    output logic                         sector_over_pulse_a,
    output logic                         sector_over_pulse_b
);
    import dsr_pkg::*;

    // Settling counter width and its terminal value.
    localparam int SW = $clog2(SETTLE_CYC + 1);
    localparam logic [SW-1:0] SET_LAST = SW'(SETTLE_CYC - 1);

    // Whole state of the sequencer.
    typedef struct packed {
        dsr_state_e         st;        // File-control state.
        logic [1:0]         cmd;       // Command code bits.
        logic [0:ACC_W-1]   acc;       // File data accumulator.
        logic [BSC_W-1:0]   bsc;       // Bit-shift counter.
        logic [WC_W-1:0]    wc;        // Word counter.
        logic               par_ph;    // Next bit is a parity bit.
        logic               char_odd;  // Second character of the word.
        logic               ovf;       // Overflow seen in this chain.
        logic [CH_N-1:0]    chain;     // Data clock chain.
        logic               bit_val;   // Value of the current bit.
        logic               bit_par;   // Current bit is parity.
        logic [TMR_W-1:0]   tmr;       // Sector gap and finish timer.
        logic [SW-1:0]      set_cnt;   // Command wait timer.
        logic [FLG_N-1:0]   flags;     // Error-status flags.
        logic [EVT_N-1:0]   tgl_prev;  // Last synchronised toggles.
        logic               rd_cmd;    // Read level copy.
        logic               rx_en;     // Receive enable copy.
        logic               permit;    // Command change permit copy.
        dsr_status_s        stat;      // Status word.
        dsr_chan_s          ch;        // Channel pulses.
        dsr_drive_s         drv;       // Drive pulses.
        logic               sd;        // Settle done strobe.
        logic               sa;        // First sector-over strobe.
        logic               sb;        // Second sector-over strobe.
    } dsr_top_s;

    dsr_top_s r;                       // Registered state.
    dsr_top_s n;                       // Next state.

    logic [EVT_N-1:0] evt_tgl;         // Toggles from the link domain.
    logic [EVT_N-1:0] evt_sync;        // Toggles after synchronising.
    logic [EVT_N-1:0] evt;             // One-cycle event strobes.
    logic             in_sec;          // In-sector state now.
    logic             rx;              // Receive enable now.
    logic             rd_en;           // Take and stop enable.
    logic             start;           // A bit starts the chain.
    logic             clr;             // Flag-clear pulse.
    logic [FLG_N-1:0] sets;            // Flag set requests.
    logic [BSC_W-1:0] bsc_inc;         // Counter plus one.

    // Link-side toggle generator on the drive's clock.
    dsr_link u_link (
        .link_clk  (link_clk),
        .rst_b     (rst_b),
        .pin_one   (pin_one),
        .pin_zero  (pin_zero),
        .pin_wclk  (pin_wclk),
        .pin_error (pin_error),
        .evt_tgl   (evt_tgl)
    );

    // Toggles cross into the system clock through two flops.
    dsr_sync #(
        .W (EVT_N)
    ) u_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .d     (evt_tgl),
        .q     (evt_sync)
    );

    // Next-state logic of the whole block.
    always_comb
    begin
        n = r;
        n.ch = '0;
        n.drv = '0;
        n.sd = 1'b0;
        n.sa = 1'b0;
        n.sb = 1'b0;
        // Edge detect on the synchronised toggles.
        evt = evt_sync ^ r.tgl_prev;
        n.tgl_prev = evt_sync;
        in_sec = (r.st == ST_INSEC);
        rx = r.cmd[1] & in_sec & ~r.wc[WC_TOP];
        rd_en = ~r.cmd[0] & in_sec;
        clr = host_ctl.io_bus_reset | host_ctl.addr_load
            | (host_ctl.ctl_load & host_ctl.control_word_bit28);
        sets = ext_flag_set;
        bsc_inc = r.bsc + BSC_PRESET[BSC_W-1:1];

        // The command code is frozen while a sector is in progress.
        if (host_ctl.ctl_load && (r.st != ST_INSEC))
        begin
            n.cmd = host_ctl.ctl_cmd_bits;
        end

        // Data bits start the chain when receiving, write clocks otherwise.
        start = (rx ? (evt[EVT_ONE] | evt[EVT_ZERO]) : evt[EVT_WCLK])
              && (r.chain == '0);
        n.chain = {r.chain[CH_N-2:0], start};

        // Counting, overflow and stop are judged on the first data clock.
        if (start)
        begin
            n.bit_val = evt[EVT_ONE];
            n.bit_par = r.par_ph;
            if (!r.par_ph)
            begin
                n.bsc = bsc_inc;
                if (bsc_inc == BSC_OVF)
                begin
                    n.ovf = 1'b1;
                    // Preset weight two so the next character needs 18 clocks.
                    n.bsc = in_sec ? BSC_PRESET : BSC_ZERO;
                    n.ch.take_char = rd_en;
                end
            end
            if (rd_en && stop_request)
            begin
                n.wc[WC_TOP] = 1'b1;
            end
        end

        // Second clock shifts the accumulator right by one place.
        if (r.chain[CH_DCK2] && !r.bit_par)
        begin
            n.acc = {addr_xmit_level ? r.acc[DA_LAST] : 1'b0,
                     r.acc[0:ACC_W-2]};
        end

        // Late clock after overflow closes a character.
        if (r.chain[CH_DCK21] && r.ovf)
        begin
            if (in_sec && r.cmd[0])
            begin
                n.acc[DA_TOP:DA_LAST] = chan_word;
                n.ch.give_char = 1'b1;
                n.ch.outword_load = 1'b1;
            end
            n.char_odd = ~r.char_odd;
            if (r.char_odd && in_sec)
            begin
                n.par_ph = 1'b1;
                n.wc = r.wc + 8'h01;
            end
        end

        // Last clock loads the received bit under CMD_READ only and ends the parity slot.
        if (r.chain[CH_DCK3])
        begin
            n.ovf = 1'b0;
            if (r.bit_par)
            begin
                n.par_ph = 1'b0;
            end
            else if (r.cmd == CMD_READ)
            begin
                n.acc[DA_TOP] = r.bit_val;
            end
        end

        // A drive error during a sector is a clocking fault.
        sets[FLG_CLK] = sets[FLG_CLK] | (evt[EVT_ERR] & in_sec);

        // File-control sequence.
        unique case (r.st)
            ST_IDLE:
            begin
                if (alert_pulse)
                begin
                    n.st = ST_ALERT;
                end
            end
            ST_ALERT:
            begin
                // The start pulse sends the command and begins settling.
                if (cmd_start_pulse)
                begin
                    n.st = ST_CMDW;
                    n.set_cnt = '0;
                    n.drv.read_pulse = r.cmd[1];
                    n.drv.write_pulse = r.cmd[0] & ~r.cmd[1];
                end
            end
            ST_CMDW:
            begin
                if (host_ctl.io_bus_reset)
                begin
                    n.st = ST_IDLE;
                end
                else if (r.set_cnt == SET_LAST)
                begin
                    // Settling over: a new sector begins.
                    n.sd = 1'b1;
                    n.st = ST_INSEC;
                    n.tmr = '0;
                    n.bsc = BSC_PRESET;
                    n.wc = '0;
                    n.par_ph = 1'b0;
                    n.char_odd = 1'b0;
                end
                else
                begin
                    n.set_cnt = r.set_cnt + 1'b1;
                end
            end
            ST_INSEC:
            begin
                // Every first data clock restarts the quiet timer.
                if (r.chain[CH_DCK1])
                begin
                    n.tmr = '0;
                end
                else if (r.tmr == GAP_LAST)
                begin
                    n.sa = 1'b1;
                    n.st = ST_FIN;
                    n.tmr = '0;
                end
                else
                begin
                    n.tmr = r.tmr + 1'b1;
                end
            end
            ST_FIN:
            begin
                if (r.tmr == FIN_LAST)
                begin
                    n.sb = 1'b1;
                    sets[FLG_SECT] = 1'b1;
                    if (r.cmd == CMD_NOP)
                    begin
                        n.st = ST_IDLE;
                    end
                    else
                    begin
                        // Another sector follows under the same command.
                        n.st = ST_CMDW;
                        n.set_cnt = '0;
                        n.drv.read_pulse = r.cmd[1];
                        n.drv.write_pulse = r.cmd[0] & ~r.cmd[1];
                    end
                end
                else
                begin
                    n.tmr = r.tmr + 1'b1;
                end
            end
            default:
            begin
                // A corrupted code falls back to idle.
                n.st = ST_IDLE;
            end
        endcase

        // Clear wipes the flags; a set in the same cycle still wins.
        n.flags = (clr ? '0 : r.flags) | sets;

        // Output copies are taken from the next state.
        n.rd_cmd = (n.cmd == CMD_READ);
        n.rx_en = n.cmd[1] & (n.st == ST_INSEC) & ~n.wc[WC_TOP];
        n.permit = (n.st != ST_INSEC);
        n.stat.in_sector_iob24 = (n.st == ST_INSEC);
        n.stat.sector_passed_iob25 = n.flags[FLG_SECT];
        n.stat.flags = n.flags;
    end

    // State register; reset puts the sequencer in idle.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            r <= '0;
            r.st <= ST_IDLE;
            r.permit <= 1'b1;
        end
        else
        begin
            r <= n;
        end
    end

    // Every output comes straight from the state register.
    assign read_cmd_level = r.rd_cmd;
    assign receive_enable_level = r.rx_en;
    assign cmd_change_permit = r.permit;
    assign fsm_state = r.st;
    assign status = r.stat;
    assign chan = r.ch;
    assign drive = r.drv;
    assign file_data_accumulator = r.acc;
    assign data_clock_first = r.chain[CH_DCK1];
    assign data_clock_late = r.chain[CH_DCK21];
    assign settle_done_pulse = r.sd;
    assign sector_over_pulse_a = r.sa;
    assign sector_over_pulse_b = r.sb;

    // Checks on the sequencer's behaviour.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_read_decode: assert property (read_cmd_level == (r.cmd == CMD_READ))
        else $error("read level does not match command code");
    a_take_coincide: assert property (chan.take_char |-> data_clock_first
        && (r.st == ST_INSEC) && !r.cmd[0])
        else $error("take character outside its data clock");
    a_finish_two_us: assert property (sector_over_pulse_a |-> ##100 sector_over_pulse_b)
        else $error("second sector-over not 100 cycles after first");
    a_enter_finish: assert property (sector_over_pulse_a |-> fsm_state == ST_FIN)
        else $error("first sector-over did not enter finish state");
    a_sector_flag: assert property (sector_over_pulse_b |-> status.sector_passed_iob25)
        else $error("sector-passed flag not set");
    a_flag_clear: assert property (host_ctl.io_bus_reset && ext_flag_set == '0
        && !evt[EVT_ERR] && !(r.st == ST_FIN) |=> status.flags == '0)
        else $error("flags not cleared");
    a_settle_step: assert property (settle_done_pulse |-> fsm_state == ST_INSEC
        && $past(r.set_cnt) == SET_LAST)
        else $error("settle done without full wait");
    a_bus_reset_wait: assert property (r.st == ST_CMDW && host_ctl.io_bus_reset
        |=> fsm_state == ST_IDLE && !settle_done_pulse)
        else $error("bus reset in command wait not honoured");
    a_rx_gate: assert property (receive_enable_level |-> status.in_sector_iob24
        && r.cmd[1] && !r.wc[WC_TOP])
        else $error("receive enable outside a read sector");
    a_permit_lock: assert property (status.in_sector_iob24 |-> !cmd_change_permit)
        else $error("command change allowed in sector");

    c_take_char: cover property (chan.take_char);
    c_give_char: cover property (chan.give_char);
    c_settle: cover property (settle_done_pulse);
    c_sector_end: cover property (sector_over_pulse_b);

endmodule : dsr_top
`default_nettype wire
